// ===== rtl/osp_top.sv
// Behaviour
// - entry 0 reads highest entry, 0x20
// - sync mode 0..3, default sync-manager
// - cycle period in ns, writable, default 1000000
// - read-only shift time SYNC0 to outputs
// - supported word 0x0807 with mode bits
// - bit 14 flags dynamic measurable times
// - read-only minimum cycle time, default 66000
// - read-only minimum SYNC0 to SYNC1 gap
// - read-only minimum SYNC1 to output delay
// - command 1 starts, 0 stops measurement
// - measuring keeps largest timing values seen
// - new measurement clears previous maxima first
// - read-only actual SYNC1 to output delay
// - count missed sync-manager events in DC
// - count late-finishing or early-starting cycles
// - count too-short SYNC0 to SYNC1 intervals
// - flag outputs driven late last DC cycle
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/10ps
module osp_top
    import osp_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // timing events
    input wire osp_evt_t EVT,
    // status
    output logic CYCLE_START,
    output logic SYNC_ERROR,
    output logic MEASURING
);

    osp_state_t q;
    osp_state_t s;

    localparam osp_state_t RST_STATE = '{
        mode: RST_SYNC_SEL, period: RST_CYCLE, shift: RST_SHIFT,
        min_cyc: RST_MIN_CYCLE, gap: RST_PAIR_GAP, max_dly: RST_MAX_DELAY,
        cmd: RST_COMMAND, meas: MS_IDLE, missed: RST_COUNT,
        overrun: RST_COUNT, short_gap: RST_COUNT, late: 1'b0,
        t_cyc: 32'h00000000, t_s0: 32'h00000000, t_s1: 32'h00000000,
        fr_ns: 32'h00000000, busy: 1'b0, sm_seen: 1'b0, drove: 1'b0,
        start: 1'b0, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0
    };

    function automatic logic [31:0] t_add(input logic [31:0] t);
        t_add = (t > TIME_MAX - TICK_NS) ? TIME_MAX : t + TICK_NS;
    endfunction

    function automatic logic [15:0] c_inc(input logic [15:0] c);
        c_inc = (c == COUNT_MAX) ? COUNT_MAX : c + 16'h0001;
    endfunction

    function automatic logic [31:0] t_max(input logic [31:0] a, input logic [31:0] b);
        t_max = (b > a) ? b : a;
    endfunction

    logic [15:0] supported;
    logic [7:0] idx;
    logic addr_ok;
    logic dc;
    logic fr_tick;
    logic start_ev;
    logic measuring;
    logic wr_commit;
    logic [32:0] fr_sum;

    always_comb begin
        supported = 16'h0000;
        supported[SUP_FREE_BIT] = 1'b1;
        supported[SUP_SM_BIT] = 1'b1;
        supported[SUP_DC_LSB +: 2] = SUP_DC_VAL;
        supported[SUP_SHIFT_LSB +: 2] = SUP_SHIFT_VAL;
        supported[SUP_DYN_BIT] = 1'b1;
        // bit 11 is set in the fixed default word
        supported = supported | RST_SUPPORTED;
    end

    always_comb begin
        s = q;
        s.pready = 1'b0;
        s.pslverr = 1'b0;
        s.start = 1'b0;
        idx = {2'h0, PADDR[ADDR_W-1:2]};
        addr_ok = (PADDR[1:0] == WORD_LSB);
        dc = (q.mode == MODE_SYNC0) || (q.mode == MODE_SYNC1);
        measuring = (q.meas == MS_RUN);
        wr_commit = PSEL && PENABLE && PWRITE && q.pready && !q.pslverr;

        // elapsed times since cycle start, SYNC0 and SYNC1
        s.t_cyc = t_add(q.t_cyc);
        s.t_s0 = EVT.sync0 ? 32'h00000000 : t_add(q.t_s0);
        s.t_s1 = EVT.sync1 ? 32'h00000000 : t_add(q.t_s1);

        // local timer period in free run
        fr_sum = {1'b0, q.fr_ns} + {1'b0, TICK_NS};
        fr_tick = (fr_sum >= {1'b0, q.period});
        s.fr_ns = fr_tick ? 32'h00000000 : fr_sum[31:0];

        // cycle start source follows the selected sync mode, with SYNC0 for both DC modes
        case (q.mode)
            MODE_FREE: start_ev = fr_tick;
            MODE_SM: start_ev = EVT.sm_event;
            MODE_SYNC0: start_ev = EVT.sync0;
            MODE_SYNC1: start_ev = EVT.sync0;
            default: start_ev = 1'b0;
        endcase

        // sync-manager event must precede every SYNC0 in DC operation
        if (EVT.sync0) begin
            if (dc && EVT.operational && !q.sm_seen) begin
                s.missed = c_inc(q.missed);
            end
            s.sm_seen = EVT.sm_event;
        end else if (EVT.sm_event) begin
            s.sm_seen = 1'b1;
        end

        if (dc && EVT.sync1 && !EVT.sync0 && (q.t_s0 < q.gap)) begin
            s.short_gap = c_inc(q.short_gap);
        end

        if (EVT.cycle_done && q.busy) begin
            s.busy = 1'b0;
            if (measuring) begin
                s.min_cyc = t_max(q.min_cyc, q.t_cyc);
                if (dc) begin
                    s.gap = t_max(q.gap, q.t_s0);
                end
            end
        end

        if (EVT.out_driven) begin
            s.drove = 1'b1;
            if (measuring && dc) begin
                s.shift = t_max(q.shift, q.t_s0);
                s.max_dly = t_max(q.max_dly, q.t_s1);
            end
        end

        if (start_ev) begin
            if (EVT.operational && q.busy) begin
                s.overrun = c_inc(q.overrun);
            end
            s.busy = 1'b1;
            s.t_cyc = 32'h00000000;
            s.start = 1'b1;
            s.drove = EVT.out_driven;
            s.late = dc && !q.drove;
        end
        if (!dc) begin
            s.late = 1'b0;
        end

        // apb setup: decode, register read data and error, answer next cycle
        if (PSEL && !PENABLE) begin
            s.pready = 1'b1;
            s.prdata = 32'h00000000;
            s.pslverr = !addr_ok;
            case (idx)
                IDX_HIGHEST: begin
                    s.prdata = {24'h000000, RST_HIGHEST};
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_SYNC_SEL: begin
                    s.prdata = {16'h0000, q.mode};
                    s.pslverr = s.pslverr || (PWRITE && (PWDATA[15:0] > MODE_SYNC1));
                end
                IDX_CYCLE: s.prdata = q.period;
                IDX_SHIFT: begin
                    s.prdata = q.shift;
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_SUPPORTED: begin
                    s.prdata = {16'h0000, supported};
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_MIN_CYCLE: begin
                    s.prdata = q.min_cyc;
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_PAIR_GAP: begin
                    s.prdata = q.gap;
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_MIN_DELAY: begin
                    s.prdata = RST_MIN_DELAY;
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_COMMAND: begin
                    s.prdata = {16'h0000, q.cmd};
                    s.pslverr = s.pslverr || (PWRITE && (PWDATA[15:0] > CMD_START));
                end
                IDX_MAX_DELAY: begin
                    s.prdata = q.max_dly;
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_MISSED: begin
                    s.prdata = {16'h0000, q.missed};
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_OVERRUN: begin
                    s.prdata = {16'h0000, q.overrun};
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_SHORT_GAP: begin
                    s.prdata = {16'h0000, q.short_gap};
                    s.pslverr = s.pslverr || PWRITE;
                end
                IDX_LATE: begin
                    s.prdata = {31'h0, q.late};
                    s.pslverr = s.pslverr || PWRITE;
                end
                default: s.pslverr = 1'b1;
            endcase
            if (s.pslverr) begin
                s.prdata = 32'h00000000;
            end
        end

        // write takes effect at the access edge; a restart clears wins over updates
        if (wr_commit) begin
            case (idx)
                IDX_SYNC_SEL: s.mode = PWDATA[15:0];
                IDX_CYCLE: begin
                    s.period = PWDATA;
                    s.fr_ns = 32'h00000000;
                end
                IDX_COMMAND: begin
                    s.cmd = PWDATA[15:0];
                    if (PWDATA[15:0] == CMD_START) begin
                        s.meas = MS_RUN;
                        s.shift = 32'h00000000;
                        s.min_cyc = 32'h00000000;
                        s.gap = 32'h00000000;
                        s.max_dly = 32'h00000000;
                    end else begin
                        s.meas = MS_IDLE;
                    end
                end
                default: s.cmd = q.cmd;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            q <= RST_STATE;
        end else begin
            q <= s;
        end
    end

    assign PRDATA = q.prdata;
    assign PREADY = q.pready;
    assign PSLVERR = q.pslverr;
    assign CYCLE_START = q.start;
    assign SYNC_ERROR = q.late;
    assign MEASURING = (q.meas == MS_RUN);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    sequence s_setup_read(logic [7:0] i);
        PSEL && !PENABLE && !PWRITE && PADDR == {i[5:0], WORD_LSB};
    endsequence

    property p_highest_read;
        s_setup_read(IDX_HIGHEST) |=> PREADY && PRDATA == 32'h00000020;
    endproperty
    a_highest_read: assert property (p_highest_read) else $error("entry count wrong");

    property p_mode_write;
        wr_commit && idx == IDX_SYNC_SEL |=> q.mode == $past(PWDATA[15:0]);
    endproperty
    a_mode_write: assert property (p_mode_write) else $error("mode write lost");

    property p_supported;
        s_setup_read(IDX_SUPPORTED) |=> PRDATA == 32'h00004827;
    endproperty
    a_supported: assert property (p_supported) else $error("supported word wrong");

    property p_restart_clear;
        wr_commit && idx == IDX_COMMAND && PWDATA[15:0] == CMD_START
            |=> MEASURING && q.shift == 32'h0 && q.max_dly == 32'h0 && q.min_cyc == 32'h0;
    endproperty
    a_restart_clear: assert property (p_restart_clear) else $error("restart kept maxima");

    property p_meas_monotonic;
        MEASURING && $stable(MEASURING) && !$past(wr_commit) |-> q.min_cyc >= $past(q.min_cyc);
    endproperty
    a_meas_monotonic: assert property (p_meas_monotonic) else $error("maximum shrank");

    property p_missed;
        EVT.sync0 && dc && EVT.operational && !q.sm_seen && q.missed != COUNT_MAX
            |=> q.missed == $past(q.missed) + 16'h0001;
    endproperty
    a_missed: assert property (p_missed) else $error("missed event not counted");

    property p_overrun;
        start_ev && q.busy && EVT.operational |=> q.overrun != 16'h0 && CYCLE_START;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun not counted");

    property p_short;
        dc && EVT.sync1 && !EVT.sync0 && q.t_s0 < q.gap && q.short_gap != COUNT_MAX
            |=> q.short_gap == $past(q.short_gap) + 16'h0001;
    endproperty
    a_short: assert property (p_short) else $error("short gap not counted");

    property p_late;
        start_ev && dc |=> SYNC_ERROR == !$past(q.drove);
    endproperty
    a_late: assert property (p_late) else $error("sync error flag wrong");

    property p_saturate;
        q.overrun == COUNT_MAX |=> q.overrun == COUNT_MAX;
    endproperty
    a_saturate: assert property (p_saturate) else $error("counter wrapped");

endmodule

// ===== common/osp_pkg.sv
package osp_pkg;
    // clock period in ns; every elapsed-time counter advances by this per clock
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam logic [31:0] TICK_NS = 32'(CLK_PERIOD_NS);

    // entry indices; the bus byte address is four times the index
    localparam logic [7:0] IDX_HIGHEST = 8'h00;
    localparam logic [7:0] IDX_SYNC_SEL = 8'h01;
    localparam logic [7:0] IDX_CYCLE = 8'h02;
    localparam logic [7:0] IDX_SHIFT = 8'h03;
    localparam logic [7:0] IDX_SUPPORTED = 8'h04;
    localparam logic [7:0] IDX_MIN_CYCLE = 8'h05;
    localparam logic [7:0] IDX_PAIR_GAP = 8'h06;
    localparam logic [7:0] IDX_MIN_DELAY = 8'h07;
    localparam logic [7:0] IDX_COMMAND = 8'h08;
    localparam logic [7:0] IDX_MAX_DELAY = 8'h09;
    localparam logic [7:0] IDX_MISSED = 8'h0B;
    localparam logic [7:0] IDX_OVERRUN = 8'h0C;
    localparam logic [7:0] IDX_SHORT_GAP = 8'h0D;
    localparam logic [7:0] IDX_LATE = 8'h20;
    localparam int unsigned ADDR_W = 8;
    localparam logic [1:0] WORD_LSB = 2'h0;

    // reset and fixed values
    localparam logic [7:0] RST_HIGHEST = 8'h20;
    localparam logic [15:0] RST_SYNC_SEL = 16'h0001;
    localparam logic [31:0] RST_CYCLE = 32'h000F4240;
    localparam logic [31:0] RST_SHIFT = 32'h00000000;
    localparam logic [15:0] RST_SUPPORTED = 16'h0807;
    localparam logic [31:0] RST_MIN_CYCLE = 32'h000101D0;
    localparam logic [31:0] RST_PAIR_GAP = 32'h00000000;
    localparam logic [31:0] RST_MIN_DELAY = 32'h00000000;
    localparam logic [15:0] RST_COMMAND = 16'h0000;
    localparam logic [31:0] RST_MAX_DELAY = 32'h00000000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [31:0] TIME_MAX = 32'hFFFFFFFF;

    // supported-modes field positions
    localparam int unsigned SUP_FREE_BIT = 0;
    localparam int unsigned SUP_SM_BIT = 1;
    localparam int unsigned SUP_DC_LSB = 2;
    localparam logic [1:0] SUP_DC_VAL = 2'h1;
    localparam int unsigned SUP_SHIFT_LSB = 4;
    localparam logic [1:0] SUP_SHIFT_VAL = 2'h2;
    localparam int unsigned SUP_DYN_BIT = 14;

    // sync mode encodings and commands
    localparam logic [15:0] MODE_FREE = 16'h0000;
    localparam logic [15:0] MODE_SM = 16'h0001;
    localparam logic [15:0] MODE_SYNC0 = 16'h0002;
    localparam logic [15:0] MODE_SYNC1 = 16'h0003;
    localparam logic [15:0] CMD_STOP = 16'h0000;
    localparam logic [15:0] CMD_START = 16'h0001;

    typedef enum logic [1:0] {
        MS_IDLE = 2'h0,
        MS_RUN = 2'h1
    } osp_meas_t;

    // timing events from the device's own logic, all on CLK; operational is a level, the others one-cycle pulses
    typedef struct packed {
        logic operational;
        logic sm_event;
        logic sync0;
        logic sync1;
        logic cycle_done;
        logic out_driven;
    } osp_evt_t;

    typedef struct packed {
        logic [15:0] mode;
        logic [31:0] period;
        logic [31:0] shift;
        logic [31:0] min_cyc;
        logic [31:0] gap;
        logic [31:0] max_dly;
        logic [15:0] cmd;
        osp_meas_t meas;
        logic [15:0] missed;
        logic [15:0] overrun;
        logic [15:0] short_gap;
        logic late;
        logic [31:0] t_cyc;
        logic [31:0] t_s0;
        logic [31:0] t_s1;
        logic [31:0] fr_ns;
        logic busy;
        logic sm_seen;
        logic drove;
        logic start;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } osp_state_t;
endpackage

// ===== tb/osp_evt_model.sv
`timescale 1ns/10ps
module osp_evt_model
    import osp_pkg::*;
(
    // clock
    input wire logic CLK,
    // timing events toward the block
    output osp_evt_t EVT
);
    initial EVT = '0;

    // operational is a level, held until changed
    task automatic set_op(input logic v);
        EVT.operational <= v;
    endtask

    // p = {sm_event, sync0, sync1, cycle_done, out_driven}, one cycle wide
    task automatic fire(input logic [4:0] p);
        {EVT.sm_event, EVT.sync0, EVT.sync1, EVT.cycle_done, EVT.out_driven} <= p;
        @(posedge CLK);
        {EVT.sm_event, EVT.sync0, EVT.sync1, EVT.cycle_done, EVT.out_driven} <= 5'h00;
        @(posedge CLK);
    endtask
endmodule

// ===== tb/osp_top_tb.sv
`timescale 1ns/10ps
module osp_top_tb;
    import osp_pkg::*;
    logic clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cyc_start;
    logic sync_err;
    logic measuring;
    osp_evt_t evt;
    int error_cnt = 0;
    int n_tests = 0;
    logic [31:0] rd;
    logic [31:0] a;
    logic er;

    osp_top dut_u (.CLK(clk), .NRST(nrst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EVT(evt), .CYCLE_START(cyc_start), .SYNC_ERROR(sync_err), .MEASURING(measuring));
    osp_evt_model m_u (.CLK(clk), .EVT(evt));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_tests++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h outside %h..%h", $time, got, lo, hi);
        end
    endtask

    function automatic logic [7:0] ba(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction

    // one apb transfer; the answer is taken at the rising edge where pready is high
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, ba(idx), d, rd, er);
        chk({31'h0, er}, 32'h0);
    endtask

    task automatic rdr(input logic [7:0] idx, output logic [31:0] d);
        apb(1'b0, ba(idx), 32'h0, d, er);
    endtask

    task automatic t_reset;
        logic [7:0] ix [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                                 8'h08, 8'h09, 8'h0B, 8'h0C, 8'h0D, 8'h20};
        logic [31:0] ex [14] = '{32'h20, 32'h1, 32'h000F4240, 32'h0, 32'h4827, 32'h000101D0,
                                 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        for (int i = 0; i < 14; i++) begin
            rdr(ix[i], rd);
            chk(rd, ex[i]);
        end
        apb(1'b1, ba(IDX_MIN_CYCLE), 32'h1, rd, er);
        chk({31'h0, er}, 32'h1);
        rdr(IDX_MIN_CYCLE, rd);
        chk(rd, RST_MIN_CYCLE);
        apb(1'b1, ba(IDX_HIGHEST), 32'h5, rd, er);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, ba(8'h0A), 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b0, 8'h05, 32'h0, rd, er);
        chk({31'h0, er}, 32'h1);
        // upper and misaligned address bits are refused too
        apb(1'b0, 8'hFE, 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
        apb(1'b0, ba(8'h10), 32'h0, rd, er);
        chk({rd[30:0], er}, 32'h1);
    endtask

    task automatic t_mode;
        logic [31:0] pat [3] = '{32'h12345678, 32'hFFFFFFFF, 32'hEDCBA987};
        for (int m = 0; m < 4; m++) begin
            wr(IDX_SYNC_SEL, 32'(m));
            rdr(IDX_SYNC_SEL, rd);
            chk(rd, 32'(m));
        end
        apb(1'b1, ba(IDX_SYNC_SEL), 32'h4, rd, er);
        chk({31'h0, er}, 32'h1);
        // every write data bit is written as both 0 and 1
        for (int p = 0; p < 3; p++) begin
            wr(IDX_CYCLE, pat[p]);
            rdr(IDX_CYCLE, rd);
            chk(rd, pat[p]);
        end
    endtask

    // free run with a 20 ns period starts a cycle every 4 clocks
    task automatic t_free;
        int cnt;
        cnt = 0;
        wr(IDX_CYCLE, 32'd20);
        wr(IDX_SYNC_SEL, MODE_FREE);
        repeat (40) begin
            @(negedge clk);
            if (cyc_start === 1'b1) cnt++;
        end
        @(posedge clk);
        chk_rng(32'(cnt), 32'd9, 32'd11);
    endtask

    task automatic t_meas;
        wr(IDX_SYNC_SEL, MODE_SYNC0);
        m_u.set_op(1'b1);
        wr(IDX_COMMAND, CMD_START);
        chk({31'h0, measuring}, 32'h1);
        rdr(IDX_MAX_DELAY, rd);
        chk(rd, 32'h0);
        m_u.fire(5'b01000);
        repeat (6) @(posedge clk);
        m_u.fire(5'b00100);
        repeat (4) @(posedge clk);
        m_u.fire(5'b00001);
        m_u.fire(5'b00010);
        rdr(IDX_SHIFT, rd);
        chk_rng(rd, 32'd65, 32'd75);
        rdr(IDX_MAX_DELAY, rd);
        chk_rng(rd, 32'd25, 32'd35);
        rdr(IDX_MIN_CYCLE, rd);
        chk_rng(rd, 32'd75, 32'd85);
        rdr(IDX_PAIR_GAP, rd);
        chk_rng(rd, 32'd75, 32'd85);
        wr(IDX_COMMAND, CMD_STOP);
        chk({31'h0, measuring}, 32'h0);
        apb(1'b1, ba(IDX_COMMAND), 32'h2, rd, er);
        chk({31'h0, er}, 32'h1);
        // a 10 ns sync0-to-sync1 gap is below the measured minimum
        rdr(IDX_SHORT_GAP, a);
        m_u.fire(5'b01000);
        m_u.fire(5'b00100);
        rdr(IDX_SHORT_GAP, rd);
        chk(rd, a + 32'h1);
        wr(IDX_COMMAND, CMD_START);
        rdr(IDX_MAX_DELAY, rd);
        chk(rd, 32'h0);
        wr(IDX_COMMAND, CMD_STOP);
    endtask

    task automatic t_counters;
        m_u.fire(5'b10000);
        m_u.fire(5'b01000);
        rdr(IDX_MISSED, a);
        m_u.fire(5'b10000);
        m_u.fire(5'b01000);
        rdr(IDX_MISSED, rd);
        chk(rd, a);
        m_u.fire(5'b01000);
        rdr(IDX_MISSED, rd);
        chk(rd, a + 32'h1);
        m_u.set_op(1'b0);
        m_u.fire(5'b01000);
        rdr(IDX_MISSED, rd);
        chk(rd, a + 32'h1);
        m_u.set_op(1'b1);
        m_u.fire(5'b00001);
        m_u.fire(5'b01000);
        rdr(IDX_LATE, rd);
        chk(rd, 32'h0);
        m_u.fire(5'b01000);
        rdr(IDX_LATE, rd);
        chk(rd, 32'h1);
        chk({31'h0, sync_err}, 32'h1);
        wr(IDX_SYNC_SEL, MODE_SM);
        rdr(IDX_LATE, rd);
        chk(rd, 32'h0);
        m_u.fire(5'b10000);
        m_u.fire(5'b00010);
        rdr(IDX_OVERRUN, a);
        m_u.fire(5'b10000);
        rdr(IDX_OVERRUN, rd);
        chk(rd, a);
        m_u.fire(5'b10000);
        rdr(IDX_OVERRUN, rd);
        chk(rd, a + 32'h1);
    endtask

    task automatic tally_and_finish;
        $display("mismatches %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        #100000;
        error_cnt++;
        $display("MISMATCH t=%0t run did not complete", $time);
        tally_and_finish();
    end

    initial begin
        nrst <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= 8'h00;
        pwdata <= 32'h00000000;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        t_reset();
        t_mode();
        t_free();
        t_meas();
        t_counters();
        tally_and_finish();
    end
endmodule
